// File: verilog/ssp_params.svh
// constants for the status panel monitor: offsets, reset values, timing
// assumes inclusion by bare name from the package and ssp_monitor
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// ***************************************************************
// register offsets (byte addresses, one word each)
// ***************************************************************
`define SSP_OFF_PON_SEL 8'h00
`define SSP_OFF_STATUS 8'h04
`define SSP_OFF_SEGMENTS 8'h08

// ***************************************************************
// field positions
// ***************************************************************
`define SSP_STAT_STATE_LSB 0
`define SSP_STAT_BB_BIT 4
`define SSP_STAT_MON_LSB 16
`define SSP_SEG_TOP_LSB 0
`define SSP_SEG_BOT_LSB 8

// ***************************************************************
// reset values and monitor numbers
// ***************************************************************
`define SSP_PON_DEFAULT 12'hFFF
`define SSP_PON_STATUS_MODE 12'hFFF
`define SSP_MON_FIRST 12'h000
`define SSP_MON_OUTPUT 12'h006
`define SSP_MON_SAFETY 12'h015
`define SSP_OUT_USED_MASK 8'h7F
`define SSP_SAF_USED_MASK 8'h03

// ***************************************************************
// timing
// ***************************************************************
`define SSP_CLK_PERIOD_NS 10
`define SSP_HOLD_TIME_MS 1000
`define SSP_HOLD_CYCLES ((`SSP_HOLD_TIME_MS * 1000000) / `SSP_CLK_PERIOD_NS)

`endif

// File: verilog/ssp_pkg.sv
// types shared by the status panel monitor modules
// assumes the constants header sits beside it
`include "ssp_params.svh"

package ssp_pkg;

  // ***************************************************************
  // panel display states
  // ***************************************************************
  typedef enum logic [1:0] {
    SSP_ST_BOOT,
    SSP_ST_STATUS,
    SSP_ST_SELECT,
    SSP_ST_DATA
  } ssp_state_e;

  typedef logic [11:0] ssp_mon_t;

endpackage

// File: verilog/ssp_key_hold.sv
// one operator key: press pulse and long-hold pulse
// assumes the key level is already synchronous and debounced
`timescale 1ns/10ps

module ssp_key_hold #(
  parameter int HOLD_CYCLES = 100
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // key level
  input wire logic key_in,
  // events
  output logic press_out,
  output logic hold_out
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYCLES - 1);
  localparam logic [CW-1:0] HOLD_FULL = CW'(HOLD_CYCLES);

  logic key_reg;
  logic [CW-1:0] cnt_reg;

  // ***************************************************************
  // edge and hold detection
  // ***************************************************************
  // previous key level for the press edge
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      key_reg <= 1'b0;
    end else if (ce_in) begin
      key_reg <= key_in;
    end
  end

  // hold counter saturates so a long hold fires only once
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
    end else if (ce_in) begin
      if (!key_in) begin
        cnt_reg <= '0;
      end else if (cnt_reg != HOLD_FULL) begin
        cnt_reg <= cnt_reg + CW'(1);
      end
    end
  end

  // registered event pulses
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      press_out <= 1'b0;
      hold_out <= 1'b0;
    end else if (ce_in) begin
      press_out <= key_in & ~key_reg;
      hold_out <= key_in & (cnt_reg == HOLD_LAST);
    end
  end

endmodule // ssp_key_hold

// File: verilog/ssp_monitor.sv
// status panel monitor: key sequence, output and safety input monitors
// assumes synchronous key and signal inputs, one clock, plain register port
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`include "ssp_params.svh"

module ssp_monitor
  import ssp_pkg::*;
#(
  parameter int HOLD_CYCLES = `SSP_HOLD_CYCLES,
  parameter logic [11:0] PON_RESET = `SSP_PON_DEFAULT
) (
  // clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  // operator keys
  input wire logic key_mode_in,
  input wire logic key_up_in,
  input wire logic key_down_in,
  input wire logic key_data_in,
  // output signal states, high while the transistor conducts
  input wire logic alarm_output_in,
  input wire logic positioning_complete_output_in,
  input wire logic speed_coincidence_output_in,
  input wire logic position_mode_in,
  input wire logic rotation_detect_output_in,
  input wire logic servo_ready_output_in,
  input wire logic alarm_code_bit_one_in,
  input wire logic alarm_code_bit_two_in,
  input wire logic alarm_code_bit_three_in,
  // safety inputs, high while the contacts are shorted
  input wire logic base_block_input_one_in,
  input wire logic base_block_input_two_in,
  // display
  output logic [7:0] seg_top_out,
  output logic [7:0] seg_bot_out,
  output logic [1:0] disp_mode_out,
  output logic [11:0] disp_number_out,
  output logic hardware_base_block_out
);

  // ***************************************************************
  // declarations
  // ***************************************************************
  ssp_state_e state_reg;
  ssp_state_e state_next;
  ssp_mon_t mon_reg;
  ssp_mon_t mon_next;
  logic [11:0] pon_sel_reg;
  logic [3:0] key_lvl_w;
  logic [3:0] key_press_w;
  logic [3:0] key_hold_w;
  logic mode_press_w;
  logic up_press_w;
  logic down_press_w;
  logic data_hold_w;
  logic [7:0] out_act_w;
  logic [7:0] saf_act_w;
  logic [7:0] top_w;
  logic [7:0] bot_w;
  logic show_out_w;
  logic show_saf_w;
  logic [31:0] rd_value_w;

  // true while the live status of one given monitor is on the display
  function automatic logic showing(input ssp_state_e st, input ssp_mon_t mon, input ssp_mon_t target);
    showing = (st == SSP_ST_DATA) && (mon == target);
  endfunction

  // ***************************************************************
  // operator keys
  // ***************************************************************
  assign key_lvl_w = {key_data_in, key_down_in, key_up_in, key_mode_in};

  // one detector per key; only data uses the long hold
  genvar gk;
  generate
    for (gk = 0; gk < 4; gk++) begin : g_key
      ssp_key_hold #(
        .HOLD_CYCLES(HOLD_CYCLES)
      ) u_key (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .key_in(key_lvl_w[gk]),
        .press_out(key_press_w[gk]),
        .hold_out(key_hold_w[gk])
      );
    end
  endgenerate

  assign mode_press_w = key_press_w[0];
  assign up_press_w = key_press_w[1];
  assign down_press_w = key_press_w[2];
  assign data_hold_w = key_hold_w[3];

  // ***************************************************************
  // signal activity vectors, LED 1 in bit 0
  // ***************************************************************
  // outputs: conducting transistor is the active state
  assign out_act_w[0] = alarm_output_in;
  assign out_act_w[1] = position_mode_in ? positioning_complete_output_in : speed_coincidence_output_in;
  assign out_act_w[2] = rotation_detect_output_in;
  assign out_act_w[3] = servo_ready_output_in;
  assign out_act_w[4] = alarm_code_bit_one_in;
  assign out_act_w[5] = alarm_code_bit_two_in;
  assign out_act_w[6] = alarm_code_bit_three_in;
  assign out_act_w[7] = 1'b0; // reserved position

  // safety: shorted contacts read as active
  assign saf_act_w[0] = base_block_input_one_in;
  assign saf_act_w[1] = base_block_input_two_in;
  assign saf_act_w[7:2] = 6'h00;

  // ***************************************************************
  // panel state machine
  // ***************************************************************
  // next state and monitor number
  always_comb begin
    state_next = state_reg;
    mon_next = mon_reg;
    case (state_reg)
      SSP_ST_BOOT: begin
        if (pon_sel_reg == `SSP_PON_STATUS_MODE) begin
          state_next = SSP_ST_STATUS;
        end else begin
          state_next = SSP_ST_DATA;
          mon_next = pon_sel_reg;
        end
      end
      SSP_ST_STATUS: begin
        if (mode_press_w) begin
          state_next = SSP_ST_SELECT;
        end
      end
      SSP_ST_SELECT: begin
        if (data_hold_w) begin
          state_next = SSP_ST_DATA;
        end else if (mode_press_w) begin
          state_next = SSP_ST_STATUS;
        end else if (up_press_w) begin
          mon_next = mon_reg + 12'h001;
        end else if (down_press_w) begin
          mon_next = mon_reg - 12'h001;
        end
      end
      SSP_ST_DATA: begin
        // stays here, refreshing, until the data key is held
        if (data_hold_w) begin
          state_next = SSP_ST_SELECT;
        end
      end
      default: begin
        state_next = SSP_ST_STATUS;
      end
    endcase
  end

  // state register; boot state decides the power-on screen
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= SSP_ST_BOOT;
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  // selected monitor number
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mon_reg <= `SSP_MON_FIRST;
    end else if (ce_in) begin
      mon_reg <= mon_next;
    end
  end

  // ***************************************************************
  // segment drive
  // ***************************************************************
  assign show_out_w = showing(state_reg, mon_reg, `SSP_MON_OUTPUT);
  assign show_saf_w = showing(state_reg, mon_reg, `SSP_MON_SAFETY);

  // per position: polarity differs between the two monitors
  genvar gp;
  generate
    for (gp = 0; gp < 8; gp++) begin : g_pos
      localparam logic [7:0] OUT_USED = `SSP_OUT_USED_MASK;
      localparam logic [7:0] SAF_USED = `SSP_SAF_USED_MASK;
      assign top_w[gp] = (show_out_w & OUT_USED[gp] & ~out_act_w[gp])
        | (show_saf_w & SAF_USED[gp] & saf_act_w[gp]);
      assign bot_w[gp] = (show_out_w & OUT_USED[gp] & out_act_w[gp])
        | (show_saf_w & SAF_USED[gp] & ~saf_act_w[gp]);
    end
  endgenerate

  // sampled every enabled cycle so the display tracks the signals
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      seg_top_out <= 8'h00;
      seg_bot_out <= 8'h00;
    end else if (ce_in) begin
      seg_top_out <= top_w;
      seg_bot_out <= bot_w;
    end
  end

  // number shown in selection mode; the mode tells which screen is up
  assign disp_mode_out = state_reg;
  assign disp_number_out = mon_reg;

  // base block follows either safety input being opened
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hardware_base_block_out <= 1'b1;
    end else if (ce_in) begin
      hardware_base_block_out <= ~base_block_input_one_in | ~base_block_input_two_in;
    end
  end

  // ***************************************************************
  // register port
  // ***************************************************************
  // power-on select; reset reloads PON_RESET, so a written value never reaches the boot state
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pon_sel_reg <= PON_RESET;
    end else if (ce_in && wr_in && addr_in == `SSP_OFF_PON_SEL) begin
      pon_sel_reg <= wr_data_in[11:0];
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_value_w = 32'h0000_0000;
    case (addr_in)
      `SSP_OFF_PON_SEL: begin
        rd_value_w[11:0] = pon_sel_reg;
      end
      `SSP_OFF_STATUS: begin
        rd_value_w[`SSP_STAT_STATE_LSB +: 2] = state_reg;
        rd_value_w[`SSP_STAT_BB_BIT] = hardware_base_block_out;
        rd_value_w[`SSP_STAT_MON_LSB +: 12] = mon_reg;
      end
      `SSP_OFF_SEGMENTS: begin
        rd_value_w[`SSP_SEG_TOP_LSB +: 8] = seg_top_out;
        rd_value_w[`SSP_SEG_BOT_LSB +: 8] = seg_bot_out;
      end
      default: begin
        rd_value_w = 32'h0000_0000;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 32'h0000_0000;
    end else if (ce_in) begin
      rd_data_out <= rd_in ? rd_value_w : 32'h0000_0000;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  sequence out_live_s;
    ce_in && state_reg == SSP_ST_DATA && mon_reg == `SSP_MON_OUTPUT;
  endsequence

  sequence saf_live_s;
    ce_in && state_reg == SSP_ST_DATA && mon_reg == `SSP_MON_SAFETY;
  endsequence

  sequence enter_data_s;
    ce_in && state_reg == SSP_ST_SELECT && data_hold_w;
  endsequence

  out_top_pol_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    out_live_s |=> seg_top_out[0] == !$past(alarm_output_in) && seg_top_out[3] == !$past(servo_ready_output_in))
    else $error("output monitor top segment wrong");

  out_bot_pol_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    out_live_s |=> seg_bot_out[2] == $past(rotation_detect_output_in) && seg_bot_out[6] == $past(alarm_code_bit_three_in))
    else $error("output monitor bottom segment wrong");

  out_led_map_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    out_live_s |=> !seg_top_out[7] && !seg_bot_out[7] && seg_bot_out[4] == $past(alarm_code_bit_one_in))
    else $error("output monitor mapping wrong");

  out_positioning_complete_output_sel_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    out_live_s |=> seg_bot_out[1] == $past(position_mode_in ? positioning_complete_output_in
      : speed_coincidence_output_in))
    else $error("coincidence position wrong");

  saf_top_pol_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    saf_live_s |=> seg_top_out[1:0] == $past({base_block_input_two_in, base_block_input_one_in}))
    else $error("safety monitor top segment wrong");

  saf_bot_pol_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    saf_live_s |=> seg_bot_out[0] == !$past(base_block_input_one_in))
    else $error("safety monitor bottom segment wrong");

  saf_reserved_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    saf_live_s |=> seg_top_out[7:2] == 6'h00 && seg_bot_out[7:2] == 6'h00)
    else $error("reserved safety position lit");

  mode_enter_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in && state_reg == SSP_ST_STATUS && mode_press_w |=> state_reg == SSP_ST_SELECT)
    else $error("mode key did not enter selection");

  step_up_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in && state_reg == SSP_ST_SELECT && !data_hold_w && !mode_press_w && up_press_w
      |=> mon_reg == $past(mon_reg) + 12'h001)
    else $error("up key did not step number");

  hold_enter_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    enter_data_s |=> state_reg == SSP_ST_DATA && $stable(mon_reg))
    else $error("hold did not show live status");

  hold_return_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in && state_reg == SSP_ST_DATA && data_hold_w |=> state_reg == SSP_ST_SELECT)
    else $error("hold did not return to number");

  boot_screen_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in && state_reg == SSP_ST_BOOT |=> (state_reg == SSP_ST_STATUS) == ($past(pon_sel_reg) == 12'hFFF))
    else $error("power-on screen wrong");

  bb_active_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in && !base_block_input_one_in |=> hardware_base_block_out)
    else $error("base block not activated");

  data_stay_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in && state_reg == SSP_ST_DATA && !data_hold_w |=> state_reg == SSP_ST_DATA)
    else $error("live status left without key");

endmodule // ssp_monitor

// File: tb/ssp_panel_model.sv
// front panel model: operator keys pressed and held the way a person would
// assumes the bench calls its tasks from one process, one key at a time
`timescale 1ns/10ps

module ssp_panel_model #(
  parameter int HOLD_CYCLES = 8
) (
  // clock
  input wire logic sys_clk_in,
  // key levels, high while pressed
  output logic key_mode_out,
  output logic key_up_out,
  output logic key_down_out,
  output logic key_data_out
);
  // all keys released at power on
  initial begin
    key_mode_out = 1'b0;
    key_up_out = 1'b0;
    key_down_out = 1'b0;
    key_data_out = 1'b0;
  end

  // ***************************************************************
  // key actions
  // ***************************************************************
  // short press; the gap after it makes the next press a fresh edge
  task automatic press(input int which);
    @(posedge sys_clk_in);
    key_mode_out <= (which == 0);
    key_up_out <= (which == 1);
    key_down_out <= (which == 2);
    repeat (2) @(posedge sys_clk_in);
    key_mode_out <= 1'b0;
    key_up_out <= 1'b0;
    key_down_out <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
  endtask

  // long hold of the data key, a few cycles past the hold count
  task automatic hold_data();
    @(posedge sys_clk_in);
    key_data_out <= 1'b1;
    repeat (HOLD_CYCLES + 4) @(posedge sys_clk_in);
    key_data_out <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
  endtask
endmodule // ssp_panel_model

// File: tb/testbench.sv
// self-checking bench for the status panel monitor
// assumes the design package and header are compiled first
`timescale 1ns/10ps

module testbench
  import ssp_pkg::*;
;
  localparam int HOLD = 8;
  logic sys_clk_in;
  logic rst_in;
  logic ce_in;
  logic [7:0] addr_in;
  logic [31:0] wr_data_in;
  logic wr_in;
  logic rd_in;
  logic [31:0] rd_data_out;
  logic key_mode, key_up, key_down, key_data;
  logic [8:0] outv;
  logic [1:0] safv;
  logic [7:0] seg_top, seg_bot, p_top, p_bot;
  logic [1:0] disp_mode, p_mode;
  logic [11:0] disp_number, p_number;
  logic hw_bb;
  logic [31:0] rdv;
  int n_fail;
  int checked;

  // ***************************************************************
  // clock, parts
  // ***************************************************************
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  ssp_panel_model #(.HOLD_CYCLES(HOLD)) panel (.sys_clk_in(sys_clk_in), .key_mode_out(key_mode),
    .key_up_out(key_up), .key_down_out(key_down), .key_data_out(key_data));

  // outv: alarm, complete, speed, pos mode, rotation, ready, code 1..3
  ssp_monitor #(.HOLD_CYCLES(HOLD)) dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .key_mode_in(key_mode), .key_up_in(key_up), .key_down_in(key_down), .key_data_in(key_data),
    .alarm_output_in(outv[0]), .positioning_complete_output_in(outv[1]), .speed_coincidence_output_in(outv[2]),
    .position_mode_in(outv[3]), .rotation_detect_output_in(outv[4]), .servo_ready_output_in(outv[5]),
    .alarm_code_bit_one_in(outv[6]), .alarm_code_bit_two_in(outv[7]), .alarm_code_bit_three_in(outv[8]),
    .base_block_input_one_in(safv[0]), .base_block_input_two_in(safv[1]), .seg_top_out(seg_top),
    .seg_bot_out(seg_bot), .disp_mode_out(disp_mode), .disp_number_out(disp_number),
    .hardware_base_block_out(hw_bb));

  // second copy whose power-on select points at the safety monitor; it shares bus and keys
  // but only its boot screen is checked, before any key moves and again after the mid-run reset
  ssp_monitor #(.HOLD_CYCLES(HOLD), .PON_RESET(12'h015)) dut_pon (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .ce_in(ce_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(),
    .key_mode_in(key_mode), .key_up_in(key_up), .key_down_in(key_down), .key_data_in(key_data),
    .alarm_output_in(outv[0]), .positioning_complete_output_in(outv[1]), .speed_coincidence_output_in(outv[2]),
    .position_mode_in(outv[3]), .rotation_detect_output_in(outv[4]), .servo_ready_output_in(outv[5]),
    .alarm_code_bit_one_in(outv[6]), .alarm_code_bit_two_in(outv[7]), .alarm_code_bit_three_in(outv[8]),
    .base_block_input_one_in(safv[0]), .base_block_input_two_in(safv[1]), .seg_top_out(p_top),
    .seg_bot_out(p_bot), .disp_mode_out(p_mode), .disp_number_out(p_number), .hardware_base_block_out());

  // ***************************************************************
  // expectations and helpers
  // ***************************************************************
  // {bottom, top}: bottom lit for a conducting output, position 8 dark
  function automatic logic [15:0] exp_out(input logic [8:0] o);
    logic [7:0] act;
    act = {1'b0, o[8], o[7], o[6], o[5], o[4], (o[3] ? o[1] : o[2]), o[0]};
    return {act, ~act & 8'h7F};
  endfunction

  // safety polarity is the reverse: top lit for shorted contacts
  function automatic logic [15:0] exp_saf(input logic [1:0] s);
    return {6'h00, ~s, 6'h00, s};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // bounded wait on the screen mode; running out ends the run
  task automatic wait_mode(input logic [1:0] m);
    for (int i = 0; i < 60; i++) begin
      if (disp_mode === m) return;
      @(posedge sys_clk_in);
      #1;
    end
    n_fail++;
    $display("FAIL wait_mode expected %h seen %h", m, disp_mode);
    tally_and_finish();
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    rdv = rd_data_out;
  endtask

  task automatic settle();
    repeat (2) @(posedge sys_clk_in);
    #1;
  endtask

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    rst_in = 1'b1;
    ce_in = 1'b1;
    addr_in = 8'h00;
    wr_data_in = 32'h00000000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    outv = 9'h000;
    safv = 2'b11;
    n_fail = 0;
    checked = 0;
    void'($urandom(32'h57115d9f));
    repeat (5) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    #1;
    check("reset mode", 32'(disp_mode), 32'(SSP_ST_BOOT));
    check("reset base block", {31'h0, hw_bb}, 32'h00000001);
    wait_mode(SSP_ST_STATUS);
    settle();
    check("pon mode", 32'(p_mode), 32'(SSP_ST_DATA));
    check("pon number", 32'(p_number), 32'h00000015);
    check("pon segs", 32'({p_bot, p_top}), 32'(exp_saf(safv)));
    reg_rd(8'h00);
    check("pon select", rdv, 32'h00000FFF);
    reg_wr(8'h00, 32'hFFFFF015);
    reg_rd(8'h00);
    check("pon select wr", rdv, 32'h00000015);
    @(posedge sys_clk_in);
    safv <= 2'b10;
    reg_wr(8'h04, 32'hFFFFFFFF);
    reg_rd(8'h04);
    check("status word", rdv, 32'h00000011);
    reg_rd(8'h0C);
    check("unmapped", rdv, 32'h00000000);
    // up is ignored on the status screen, so the first entry shows 000
    panel.press(1);
    panel.press(0);
    wait_mode(SSP_ST_SELECT);
    check("first number", 32'(disp_number), 32'h00000000);
    panel.press(2);
    check("down wrap", 32'(disp_number), 32'h00000FFF);
    panel.press(1);
    check("up wrap", 32'(disp_number), 32'h00000000);
    repeat (6) panel.press(1);
    check("output number", 32'(disp_number), 32'h00000006);
    panel.hold_data();
    wait_mode(SSP_ST_DATA);
    for (int i = 0; i < 24; i++) begin
      @(posedge sys_clk_in);
      outv <= (i == 0) ? 9'h001 : 9'($urandom);
      settle();
      check("output segs", 32'({seg_bot, seg_top}), 32'(exp_out(outv)));
    end
    // a low enable freezes the segments although the outputs move
    @(posedge sys_clk_in);
    ce_in <= 1'b0;
    outv <= ~outv;
    settle();
    check("ce freeze", 32'({seg_bot, seg_top}), 32'(exp_out(~outv)));
    @(posedge sys_clk_in);
    ce_in <= 1'b1;
    settle();
    check("ce resume", 32'({seg_bot, seg_top}), 32'(exp_out(outv)));
    reg_rd(8'h08);
    check("segment word", rdv, {16'h0000, exp_out(outv)});
    panel.press(1);
    check("data ignores up", 32'(disp_number), 32'h00000006);
    panel.hold_data();
    wait_mode(SSP_ST_SELECT);
    check("number kept", 32'(disp_number), 32'h00000006);
    check("select segs", 32'({seg_bot, seg_top}), 32'h00000000);
    repeat (15) panel.press(1);
    check("safety number", 32'(disp_number), 32'h00000015);
    // mode in selection goes back to status; the number is remembered
    panel.press(0);
    check("mode leaves", 32'(disp_mode), 32'(SSP_ST_STATUS));
    panel.press(0);
    check("mode reenters", 32'(disp_mode), 32'(SSP_ST_SELECT));
    check("number remembered", 32'(disp_number), 32'h00000015);
    panel.hold_data();
    wait_mode(SSP_ST_DATA);
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk_in);
      safv <= (i < 4) ? 2'(i) : 2'($urandom);
      settle();
      check("safety segs", 32'({seg_bot, seg_top}), 32'(exp_saf(safv)));
      check("base block", {31'h0, hw_bb}, {31'h0, ~(safv[0] & safv[1])});
    end
    // a second reset in mid-run brings back the default select
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    #1;
    wait_mode(SSP_ST_STATUS);
    check("pon mode again", 32'(p_mode), 32'(SSP_ST_DATA));
    reg_rd(8'h00);
    check("select after reset", rdv, 32'h00000FFF);
    tally_and_finish();
  end
endmodule // testbench
